// [common/wcp_defines.svh]
// Constants for the word clock port control block
`ifndef WCP_DEFINES_SVH
`define WCP_DEFINES_SVH
`define WCP_CLK_PERIOD_NS 10
`define WCP_CLK_HZ 30'd100000000
`define WCP_LOSS_TIMEOUT_NS 100000
`define WCP_LOSS_TIMEOUT_CYC ((`WCP_LOSS_TIMEOUT_NS + `WCP_CLK_PERIOD_NS - 1) / `WCP_CLK_PERIOD_NS)
`define WCP_MIN_PERIOD_CYC 12'd500
`define WCP_MAX_PERIOD_CYC 12'd3300
`define WCP_OUT_TOGGLE_MAX 1600
`define WCP_RATE_RESET 18'd48000
`define WCP_RATE_SINGLE_MIN 18'd32000
`define WCP_RATE_SINGLE_MAX 18'd48000
`define WCP_RATE_DOUBLE_MAX 18'd96000
`define WCP_AUD_SHIFT 10
`define WCP_STD_RATES '{18'd32000, 18'd44100, 18'd48000, 18'd64000, 18'd88200, 18'd96000, \
    18'd128000, 18'd176400, 18'd192000}
`define WCP_NUM_STD 9
`define WCP_OFF_CTRL 8'h00
`define WCP_OFF_RATE 8'h04
`define WCP_OFF_STATUS 8'h08
`define WCP_OFF_CUR_RATE 8'h0c
`define WCP_OFF_INT_STAT 8'h10
`define WCP_OFF_INT_MASK 8'h14
`define WCP_CTRL_DIR_OUT 0
`define WCP_CTRL_SLAVE 1
`define WCP_CTRL_SINGLE 2
`define WCP_CTRL_SRC_EXT 3
`define WCP_CTRL_RESET 4'h0
`define WCP_INT_DETECT 0
`define WCP_INT_LOST 1
`define WCP_INT_LOCK 2
`define WCP_RESP_OKAY 2'b00
`define WCP_RESP_SLVERR 2'b10
`endif

// [common/wcp_meas_if.sv]
// Word clock measurement results passed to the controller
`timescale 1ns/1ps
interface wcp_meas_if;
    logic en;
    logic detect;
    logic valid;
    logic edge_p;
    logic lost_p;
    wcp_pkg::wcp_period_type period;
    modport meas (input en, output detect, output valid, output edge_p, output lost_p,
        output period);
    modport ctl (output en, input detect, input valid, input edge_p, input lost_p,
        input period);
endinterface : wcp_meas_if

// [common/wcp_pkg.sv]
// Types for the word clock port control block
package wcp_pkg;
    typedef enum {CS_MASTER, CS_SLAVE, CS_FALLBACK} wcp_clk_state_type;
    typedef logic [17:0] wcp_rate_type;
    typedef logic [11:0] wcp_period_type;
endpackage : wcp_pkg

// [rtl/wcp_ctrl.sv]
// Word clock port control: direction, clock mode, fallback, output and audio clocks
//
// Overview of operation
// - The BNC port is either input or output, chosen by a control bit.
// - In output mode the word clock runs continuously at the current rate.
// - Master mode takes the output rate from the software rate register.
// - Slave mode outputs the rate of the selected external source.
// - On reference loss, fall back to master at the nearest standard rate.
// - Single speed clamp divides the output down into 32 to 48 kHz.
// - Regenerate an audio clock at 512 times the single speed rate (24.576 MHz at 48 kHz) locked to incoming word clock.
// - Light the detect indicator as soon as a word clock is seen.
// - Report word clock as current source only while its signal is valid.
// - A source select bit lets word clock be the followed reference.
// - Input accepts single, double or quad rate word clock automatically.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wcp_defines.svh"
module wcp_ctrl #(
    parameter int TIMEOUT_CYC = `WCP_LOSS_TIMEOUT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wc_in,
    output logic wc_out,
    output logic wc_oe_n,
    input wire wcp_pkg::wcp_rate_type ext_src_rate,
    input wire logic ext_src_valid,
    output logic wordclk_detect_indicator,
    output logic audio_clk,
    output logic irq
);
    import wcp_pkg::*;
    localparam wcp_rate_type STD_RATES [0:`WCP_NUM_STD-1] = `WCP_STD_RATES;

    function automatic wcp_rate_type nearest_rate(input wcp_rate_type r);
        wcp_rate_type best;
        wcp_rate_type err;
        wcp_rate_type best_err;
        best = STD_RATES[0];
        best_err = 18'h3ffff;
        for (int i = 0; i < `WCP_NUM_STD; i++) begin
            err = (r > STD_RATES[i]) ? r - STD_RATES[i] : STD_RATES[i] - r;
            if (err < best_err) begin
                best_err = err;
                best = STD_RATES[i];
            end
        end
        return best;
    endfunction : nearest_rate

    function automatic wcp_rate_type rate_of_period(input wcp_period_type p);
        wcp_rate_type best;
        logic [29:0] prod;
        logic [29:0] err;
        logic [29:0] best_err;
        best = STD_RATES[0];
        best_err = 30'h3fffffff;
        for (int i = 0; i < `WCP_NUM_STD; i++) begin
            prod = 30'(STD_RATES[i]) * 30'(p);
            err = (prod > `WCP_CLK_HZ) ? prod - `WCP_CLK_HZ : `WCP_CLK_HZ - prod;
            if (err < best_err) begin
                best_err = err;
                best = STD_RATES[i];
            end
        end
        return best;
    endfunction : rate_of_period

    function automatic wcp_rate_type clamp_single(input wcp_rate_type r);
        if (r > `WCP_RATE_DOUBLE_MAX) begin
            return r >> 2;
        end else if (r > `WCP_RATE_SINGLE_MAX) begin
            return r >> 1;
        end
        return r;
    endfunction : clamp_single

    wcp_meas_if mi ();

    wcp_wc_meas #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_meas (
        .aclk(aclk),
        .aresetn(aresetn),
        .wc_in(wc_in),
        .mi(mi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus
    logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d, wmask;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [3:0] ctrl_q, ctrl_d;
    wcp_rate_type rate_q, rate_d;
    logic [2:0] int_stat_q, int_stat_d, int_mask_q, int_mask_d, int_ev;
    logic do_wr;
    logic [31:0] status_word;
    wcp_rate_type eff_rate_q, eff_rate_d, out_rate;
    wcp_clk_state_type st_q, st_d;
    logic src_ok, cur_src_word;

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{s_axi_wstrb[b]}};
        end
    end

    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d = w_full_q;
        w_data_d = w_data_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ctrl_d = ctrl_q;
        rate_d = rate_q;
        int_mask_d = int_mask_q;
        int_stat_d = int_stat_q;
        do_wr = aw_full_q && w_full_q && !bvalid_q;
        if (s_axi_awvalid && !aw_full_q) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_q) begin
            w_full_d = 1'b1;
            w_data_d = (s_axi_wdata & wmask) | (w_data_q & ~wmask);
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `WCP_RESP_OKAY;
            unique case ({aw_addr_q[7:2], 2'b00})
                `WCP_OFF_CTRL: ctrl_d = w_data_q[3:0];
                `WCP_OFF_RATE: rate_d = w_data_q[17:0];
                `WCP_OFF_INT_STAT: int_stat_d = int_stat_q & ~w_data_q[2:0];
                `WCP_OFF_INT_MASK: int_mask_d = w_data_q[2:0];
                `WCP_OFF_STATUS, `WCP_OFF_CUR_RATE: bresp_d = `WCP_RESP_OKAY;
                default: bresp_d = `WCP_RESP_SLVERR;
            endcase
        end
        // Hardware set wins over a clearing write in the same cycle
        int_stat_d = int_stat_d | int_ev;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d = `WCP_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `WCP_OFF_CTRL: rdata_d = {28'h0000000, ctrl_q};
                `WCP_OFF_RATE: rdata_d = {14'h0000, rate_q};
                `WCP_OFF_STATUS: rdata_d = status_word;
                `WCP_OFF_CUR_RATE: rdata_d = {14'h0000, eff_rate_q};
                `WCP_OFF_INT_STAT: rdata_d = {29'h00000000, int_stat_q};
                `WCP_OFF_INT_MASK: rdata_d = {29'h00000000, int_mask_q};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = `WCP_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q <= 1'b0;
            w_data_q <= 32'h00000000;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
            ctrl_q <= `WCP_CTRL_RESET;
            rate_q <= `WCP_RATE_RESET;
            int_stat_q <= 3'h0;
            int_mask_q <= 3'h0;
        end else begin
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q <= w_full_d;
            w_data_q <= w_data_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ctrl_q <= ctrl_d;
            rate_q <= rate_d;
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock mode and rate selection
    wcp_rate_type src_rate, last_rate_q, last_rate_d;
    logic dir_out, word_sel, ind_q, ind_d;

    assign dir_out = ctrl_q[`WCP_CTRL_DIR_OUT];
    assign word_sel = !ctrl_q[`WCP_CTRL_SRC_EXT];
    assign mi.en = !dir_out;
    assign src_ok = word_sel ? mi.valid : ext_src_valid;
    assign src_rate = word_sel ? rate_of_period(mi.period) : ext_src_rate;
    assign cur_src_word = word_sel && !dir_out && mi.valid && (st_q == CS_SLAVE);
    assign out_rate = ctrl_q[`WCP_CTRL_SINGLE] ? clamp_single(eff_rate_q) : eff_rate_q;
    assign status_word = {24'h000000, 1'b0, (st_q != CS_SLAVE), (st_q == CS_FALLBACK),
        src_ok, cur_src_word, mi.valid, mi.detect, dir_out};

    always_comb begin
        st_d = st_q;
        eff_rate_d = eff_rate_q;
        last_rate_d = src_ok ? src_rate : last_rate_q;
        int_ev = 3'h0;
        // Detect rose: indicator register still holds the old detect
        int_ev[`WCP_INT_DETECT] = mi.detect && !ind_q;
        unique case (st_q)
            CS_MASTER: begin
                if (ctrl_q[`WCP_CTRL_SLAVE]) begin
                    st_d = src_ok ? CS_SLAVE : CS_FALLBACK;
                end
            end
            CS_SLAVE: begin
                if (!ctrl_q[`WCP_CTRL_SLAVE]) begin
                    st_d = CS_MASTER;
                end else if (!src_ok) begin
                    st_d = CS_FALLBACK;
                    int_ev[`WCP_INT_LOST] = 1'b1;
                end
            end
            CS_FALLBACK: begin
                if (!ctrl_q[`WCP_CTRL_SLAVE]) begin
                    st_d = CS_MASTER;
                end else if (src_ok) begin
                    st_d = CS_SLAVE;
                    int_ev[`WCP_INT_LOCK] = 1'b1;
                end
            end
        endcase
        unique case (st_d)
            CS_MASTER: eff_rate_d = rate_q;
            CS_SLAVE: eff_rate_d = src_rate;
            CS_FALLBACK: eff_rate_d = nearest_rate(last_rate_q);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= CS_MASTER;
            last_rate_q <= `WCP_RATE_RESET;
            eff_rate_q <= `WCP_RATE_RESET;
        end else begin
            st_q <= st_d;
            last_rate_q <= last_rate_d;
            eff_rate_q <= eff_rate_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output word clock and regenerated audio clock
    logic [29:0] wacc_q, wacc_d, wsum, aacc_q, aacc_d, asum;
    logic wclk_q, wclk_d, aclk_out_q, aclk_out_d, lock_edge;
    logic [10:0] idle_q, idle_d;

    assign lock_edge = mi.edge_p && word_sel && (st_q == CS_SLAVE);

    always_comb begin
        wsum = wacc_q + 30'({out_rate, 1'b0});
        asum = aacc_q + 30'({clamp_single(eff_rate_q), 10'h000});
        wacc_d = wsum;
        wclk_d = wclk_q;
        aacc_d = asum;
        aclk_out_d = aclk_out_q;
        ind_d = mi.detect;
        idle_d = idle_q;
        // Free running, never gated, while the port drives
        if (!dir_out) begin
            wacc_d = '0;
            wclk_d = 1'b0;
        end else if (wsum >= `WCP_CLK_HZ) begin
            wacc_d = wsum - `WCP_CLK_HZ;
            wclk_d = !wclk_q;
        end
        // Cycles since the output last toggled, saturating
        if (!dir_out || wclk_d != wclk_q) begin
            idle_d = 11'h000;
        end else if (idle_q != 11'h7ff) begin
            idle_d = idle_q + 11'h001;
        end
        if (lock_edge) begin
            aacc_d = '0;
            aclk_out_d = 1'b1;
        end else if (asum >= `WCP_CLK_HZ) begin
            aacc_d = asum - `WCP_CLK_HZ;
            aclk_out_d = !aclk_out_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wacc_q <= '0;
            wclk_q <= 1'b0;
            aacc_q <= '0;
            aclk_out_q <= 1'b0;
            ind_q <= 1'b0;
            idle_q <= 11'h000;
        end else begin
            wacc_q <= wacc_d;
            wclk_q <= wclk_d;
            aacc_q <= aacc_d;
            aclk_out_q <= aclk_out_d;
            ind_q <= ind_d;
            idle_q <= idle_d;
        end
    end

    assign wc_out = wclk_q;
    assign wc_oe_n = !dir_out;
    assign audio_clk = aclk_out_q;
    assign wordclk_detect_indicator = ind_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_ref_lost;
        (st_q == CS_SLAVE) && ctrl_q[`WCP_CTRL_SLAVE] && !src_ok;
    endsequence
    sequence seq_fallback_std;
        (st_q == CS_FALLBACK) && (eff_rate_q == nearest_rate(last_rate_q));
    endsequence

    chk_port_direction: assert property (
        (wc_oe_n == !dir_out) and ($past(dir_out) |-> !mi.detect))
        else $error("port direction inconsistent");
    chk_output_running: assert property (
        dir_out && out_rate >= `WCP_RATE_SINGLE_MIN |-> idle_q < 11'(`WCP_OUT_TOGGLE_MAX))
        else $error("word clock output stalled");
    chk_master_rate: assert property (
        st_q == CS_MASTER && $stable(rate_q) |-> eff_rate_q == rate_q)
        else $error("master rate mismatch");
    chk_slave_rate: assert property (
        st_q == CS_SLAVE && $past(st_q) == CS_SLAVE && $stable(src_rate)
        |-> eff_rate_q == src_rate)
        else $error("slave rate mismatch");
    chk_fallback_entry: assert property (seq_ref_lost |=> seq_fallback_std)
        else $error("no fallback after reference loss");
    chk_clamp_range: assert property (
        ctrl_q[`WCP_CTRL_SINGLE] |-> out_rate <= `WCP_RATE_SINGLE_MAX)
        else $error("single speed clamp exceeded");
    chk_audio_lock: assert property (lock_edge |=> audio_clk && aacc_q == 30'h0)
        else $error("audio clock not aligned to word clock");
    chk_indicator_follow: assert property (mi.detect |=> wordclk_detect_indicator)
        else $error("indicator not lit");
    chk_current_source: assert property (
        cur_src_word |-> mi.valid && mi.detect && src_ok)
        else $error("word source reported without valid signal");
    chk_irq_level: assert property (irq == |(int_stat_q & int_mask_q))
        else $error("interrupt level wrong");
endmodule : wcp_ctrl

// [rtl/wcp_wc_meas.sv]
// Word clock input edge detection, period measurement and loss timeout
`timescale 1ns/1ps
`include "wcp_defines.svh"
module wcp_wc_meas #(
    parameter int TIMEOUT_CYC = `WCP_LOSS_TIMEOUT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wc_in,
    wcp_meas_if.meas mi
);
    import wcp_pkg::*;
    localparam int CW = $clog2(TIMEOUT_CYC + 1);
    localparam logic [CW-1:0] TMO = CW'(TIMEOUT_CYC);

    if (TIMEOUT_CYC <= int'(`WCP_MAX_PERIOD_CYC)) begin : g_bad_timeout
        $error("TIMEOUT_CYC must exceed the longest word clock period");
    end

    logic prev_q, prev_d;
    logic [CW-1:0] cnt_q, cnt_d;
    wcp_period_type per_q, per_d, per_new, diff;
    logic det_q, det_d, val_q, val_d, edge_q, edge_d, lost_q, lost_d;
    logic in_range;

    always_comb begin
        prev_d = wc_in;
        cnt_d = cnt_q;
        per_d = per_q;
        det_d = det_q;
        val_d = val_q;
        edge_d = 1'b0;
        lost_d = 1'b0;
        in_range = (cnt_q >= CW'(`WCP_MIN_PERIOD_CYC)) && (cnt_q <= CW'(`WCP_MAX_PERIOD_CYC));
        per_new = in_range ? cnt_q[11:0] : 12'h000;
        diff = (per_new > per_q) ? per_new - per_q : per_q - per_new;
        if (!mi.en) begin
            cnt_d = '0;
            per_d = '0;
            det_d = 1'b0;
            val_d = 1'b0;
        end else if (wc_in && !prev_q) begin
            // Any speed in range is accepted; steady period marks it valid
            per_d = per_new;
            det_d = 1'b1;
            val_d = det_q && in_range && (per_q != 12'h000) && (diff <= (per_q >> 4));
            cnt_d = CW'(1);
            edge_d = 1'b1;
        end else if (cnt_q == TMO) begin
            det_d = 1'b0;
            val_d = 1'b0;
            per_d = '0;
            lost_d = det_q;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
            cnt_q <= '0;
            per_q <= '0;
            det_q <= 1'b0;
            val_q <= 1'b0;
            edge_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
            det_q <= det_d;
            val_q <= val_d;
            edge_q <= edge_d;
            lost_q <= lost_d;
        end
    end

    assign mi.detect = det_q;
    assign mi.valid = val_q;
    assign mi.edge_p = edge_q;
    assign mi.lost_p = lost_q;
    assign mi.period = per_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_loss_timeout: assert property (
        mi.en && cnt_q == TMO && !(wc_in && !prev_q) |=> !det_q)
        else $error("detect not dropped at timeout");
    chk_edge_detect: assert property (mi.en && wc_in && !prev_q |=> det_q && edge_q)
        else $error("edge not detected");
endmodule : wcp_wc_meas

// [verif/tb.sv]
// Self-checking testbench for the word clock port controller
`timescale 1ns/1ps
`include "wcp_defines.svh"
module tb;
    import wcp_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, wc_out, wc_oe_n, src_wc, src_en;
    logic ext_valid, ind, audio_clk, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [11:0] half;
    wcp_rate_type ext_rate;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [17:0] std_r[9] = `WCP_STD_RATES;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    initial begin
        aclk = 1'b0;
        forever #5 aclk = !aclk;
    end
    wcp_ctrl #(.TIMEOUT_CYC(4000)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wc_in(wc_oe_n ? src_wc : wc_out), .wc_out(wc_out), .wc_oe_n(wc_oe_n),
        .ext_src_rate(ext_rate), .ext_src_valid(ext_valid), .wordclk_detect_indicator(ind),
        .audio_clk(audio_clk), .irq(irq));
    // Far side drives only while this device listens
    wcp_wc_src src (.aclk(aclk), .en(src_en && wc_oe_n), .half_cyc(half), .wc(src_wc));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp_val(string nm, logic [33:0] e, logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val
    task automatic cmp_near(string nm, int e, int g, int tol);
        comparisons++;
        if (g < e - tol || g > e + tol) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_near
    // Results are matched against the oldest noted expectation
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready) cmp_val("read", exp_r.pop_front(), {rresp, rdata});
        if (bvalid === 1'b1 && bready) cmp_val("bresp", {32'h0, exp_b.pop_front()}, {32'h0, bresp});
    end
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        logic aw, w, b;
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        b = 1'b0;
        while (!b && n < 100) begin
            #1;
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            @(posedge aclk);
            n++;
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        if (!b) to_fail();
    endtask : wr
    task automatic rd(logic [7:0] a, logic [33:0] e);
        logic ar, r;
        exp_r.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        r = 1'b0;
        while (!r && n < 100) begin
            #1;
            ar = arvalid && arready;
            r = rvalid;
            @(posedge aclk);
            n++;
            if (ar) arvalid <= 1'b0;
        end
        if (!r) to_fail();
    endtask : rd
    task automatic to_fail();
        error_cnt++;
        end_of_test();
    endtask : to_fail
    task automatic cnt_rise(bit sel, int cyc, output int k);
        logic p;
        k = 0;
        p = sel ? audio_clk : wc_out;
        repeat (cyc) begin
            @(posedge aclk);
            #1;
            if ((sel ? audio_clk : wc_out) && !p) k++;
            p = sel ? audio_clk : wc_out;
        end
    endtask : cnt_rise
    function automatic int out_hz(logic [3:0] c, int r);
        if (!c[2] || r <= 48000) return r;
        return r > 96000 ? r / 4 : r / 2;
    endfunction : out_hz
    initial begin
        repeat (99000) @(posedge aclk);
        to_fail();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k, i;
        logic [3:0] c;
        logic [17:0] r;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, src_en, ext_valid} = 8'h00;
        {awaddr, araddr, wdata, ext_rate} = 66'h0;
        half = 12'd1042;
        void'($urandom(56005));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp_val("oe_n", 34'h1, {33'h0, wc_oe_n});
        rd(`WCP_OFF_CTRL, 34'h0);
        rd(`WCP_OFF_RATE, {2'b00, 32'd48000});
        rd(8'h18, {`WCP_RESP_SLVERR, 32'h0});
        wr(8'h18, 32'h1, `WCP_RESP_SLVERR);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            c = (i == 0) ? 4'h1 : 4'h5;
            r = (i < 2) ? 18'd96000 : (i == 2) ? 18'd192000 : std_r[$urandom % 9];
            wr(`WCP_OFF_RATE, {14'h0, r}, `WCP_RESP_OKAY);
            wr(`WCP_OFF_CTRL, {28'h0, c}, `WCP_RESP_OKAY);
            rd(`WCP_OFF_CUR_RATE, {16'h0, r});
            cmp_val("oe_n", 34'h0, {33'h0, wc_oe_n});
            repeat (2100) @(posedge aclk);
            cnt_rise(1'b0, 10000, k);
            cmp_near("wc_out", (out_hz(c, r) + 5000) / 10000, k, 1);
        end
        $display("test output mode done");
        wr(`WCP_OFF_CTRL, 32'ha, `WCP_RESP_OKAY);
        ext_rate <= std_r[$urandom % 9];
        ext_valid <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(`WCP_OFF_CUR_RATE, {16'h0, ext_rate});
        wr(`WCP_OFF_CTRL, 32'h2, `WCP_RESP_OKAY);
        cmp_val("oe_n", 34'h1, {33'h0, wc_oe_n});
        src_en <= 1'b1;
        for (i = 0; i < 3; i++) begin
            half <= 12'd1042 >> i;
            repeat (12 * (1042 >> i)) @(posedge aclk);
            cmp_val("indicator", 34'h1, {33'h0, ind});
            rd(`WCP_OFF_STATUS, 34'h1e);
            rd(`WCP_OFF_CUR_RATE, {16'h0, std_r[3 * i + 2]});
            cnt_rise(1'b1, 1000, k);
            cmp_near("audio_clk", 246, k, 3);
        end
        $display("test input mode done");
        rd(`WCP_OFF_INT_STAT, 34'h7);
        wr(`WCP_OFF_INT_STAT, 32'h7, `WCP_RESP_OKAY);
        wr(`WCP_OFF_INT_MASK, 32'h2, `WCP_RESP_OKAY);
        cmp_val("irq", 34'h0, {33'h0, irq});
        src_en <= 1'b0;
        repeat (4500) @(posedge aclk);
        cmp_val("indicator", 34'h0, {33'h0, ind});
        cmp_val("irq", 34'h1, {33'h0, irq});
        rd(`WCP_OFF_STATUS, 34'h60);
        rd(`WCP_OFF_CUR_RATE, {16'h0, 18'd192000});
        rd(`WCP_OFF_INT_STAT, 34'h2);
        wr(`WCP_OFF_INT_MASK, 32'h0, `WCP_RESP_OKAY);
        cmp_val("irq", 34'h0, {33'h0, irq});
        wr(`WCP_OFF_INT_MASK, 32'h2, `WCP_RESP_OKAY);
        cmp_val("irq", 34'h1, {33'h0, irq});
        wr(`WCP_OFF_INT_STAT, 32'h2, `WCP_RESP_OKAY);
        cmp_val("irq", 34'h0, {33'h0, irq});
        $display("test loss done");
        end_of_test();
    end
endmodule : tb

// [verif/wcp_wc_src.sv]
// Word clock source standing on the far side of the port
`timescale 1ns/1ps
module wcp_wc_src (
    input wire logic aclk,
    input wire logic en,
    input wire logic [11:0] half_cyc,
    output logic wc
);
    logic [11:0] cnt_q = 12'h000;
    initial wc = 1'b0;
    // Square wave while enabled; the termination pulls a silent line low
    always @(posedge aclk) begin
        if (!en) begin
            wc <= 1'b0;
            cnt_q <= 12'h000;
        end else if (cnt_q >= half_cyc - 12'h001) begin
            wc <= !wc;
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_q + 12'h001;
        end
    end
endmodule : wcp_wc_src
